// ---- core/tpwm_core.sv ----
// Timer based 10-bit PWM generator with AHB-Lite register slave.
// Assumes one clock (hclk) as the quarter-cycle source and a single AHB-Lite master.
//
// What this block does
// - Period equals (limit+1) times four times prescale
// - Timer clears after reaching period limit
// - Period end sets output unless duty zero
// - Period end latches duty into active buffer
// - Postscaler never alters PWM period
// - Duty is high byte plus two low bits
// - Active duty buffer is read only
// - New duty applies only after period end
// - Output clears when active duty matches timer
// - Duty beyond period leaves output unchanged
// - Resolution is log2 of four times (limit+1)
// - Prescaler divides by 1, 4 or 16
// - Sleep freezes timer, state and output
// - Software fail-safe bit drives clk_fail_select
// - Reset restores inputs and register reset values
// - PWM starts at next timer reset
// - Timer flag set on period rollover
// - Clearing mode control forces output low
`timescale 1ns/100ps
`include "tpwm_defines.svh"

module tpwm_core #(
   parameter int HADDR_W = 12
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [HADDR_W-1:0] haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic      [31:0]        hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   input  wire logic               pin_in,
   output logic                    pwm_out,
   output logic                    pwm_oe,
   output logic                    post_event,
   output logic                    clk_fail_select
);
   import tpwm_pkg::*;

   logic [7:0]     mode_ctrl;
   logic [7:0]     duty_high_bits;
   logic [7:0]     active_duty_buffer;
   logic [1:0]     active_low_latch;
   logic [7:0]     irq_enable;
   logic [7:0]     irq_flags;
   logic [7:0]     period_limit;
   logic [7:0]     timer_ctrl;
   logic [7:0]     period_timer_count;
   logic [7:0]     port_dir;
   logic [1:0]     sys_ctrl;
   logic [1:0]     qclk;
   logic [3:0]     pre_cnt;
   logic [3:0]     post_cnt;
   logic           pwm_latch;
   logic           dp_write;
   logic           dp_read;
   logic [HADDR_W-1:0] dp_addr;
   logic           sleep;
   logic           pwm_mode;
   logic           inc_tick;
   logic           period_end;
   logic [1:0]     sub_bits;
   tpwm_duty_t     active_duty;
   tpwm_duty_t     pending_duty;
   tpwm_duty_t     timebase;
   tpwm_prescale_t pre_sel;
   logic [3:0]     pre_max;
   logic           wr_mode;
   logic           wr_timer;
   logic           wr_flags;
   logic [7:0]     wdat;

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wdat      = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
         dp_addr  <= '0;
      end else if (hready) begin
         dp_write <= hsel && htrans[1] && hwrite;
         dp_read  <= hsel && htrans[1] && !hwrite;
         dp_addr  <= haddr;
      end else begin
         dp_write <= 1'b0;
         dp_read  <= 1'b0;
      end
   end

   assign wr_mode  = dp_write && (dp_addr == `TPWM_OFS_MODE_CTRL);
   assign wr_timer = dp_write && (dp_addr == `TPWM_OFS_TIMER_COUNT);
   assign wr_flags = dp_write && (dp_addr == `TPWM_OFS_IRQ_FLAGS);

   assign sleep           = sys_ctrl[`TPWM_SLEEP_BIT];
   assign clk_fail_select = sys_ctrl[`TPWM_FAILSAFE_BIT];
   assign pwm_mode = (mode_ctrl[`TPWM_MODE_MSB:`TPWM_MODE_LSB] == `TPWM_MODE_PWM);
   assign pre_sel  = tpwm_prescale_t'(timer_ctrl[`TPWM_PRE_MSB:`TPWM_PRE_LSB]);

   always_comb begin
      unique case (pre_sel)
         TPWM_PRE_DIV1:  pre_max = 4'h0;
         TPWM_PRE_DIV4:  pre_max = 4'h3;
         TPWM_PRE_DIV16, TPWM_PRE_DIV16B: pre_max = 4'hF;
      endcase
   end

   // Quarter cycle clock: four hclk per instruction cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         qclk <= 2'h0;
      end else if (!sleep) begin
         qclk <= qclk + 2'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt <= 4'h0;
      end else if (!sleep && timer_ctrl[`TPWM_RUN_BIT] && qclk == 2'h3) begin
         pre_cnt <= (pre_cnt >= pre_max) ? 4'h0 : pre_cnt + 4'h1;
      end
   end

   assign inc_tick   = !sleep && timer_ctrl[`TPWM_RUN_BIT] && (qclk == 2'h3) && (pre_cnt >= pre_max);
   assign period_end = inc_tick && (period_timer_count == period_limit);

   // Period timer; a software write also loads it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_timer_count <= `TPWM_RST_TIMER_COUNT;
      end else if (wr_timer) begin
         period_timer_count <= wdat;
      end else if (period_end) begin
         period_timer_count <= 8'h00;
      end else if (inc_tick) begin
         period_timer_count <= period_timer_count + 8'h01;
      end
   end

   // Postscaler divides period events only, never the period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         post_cnt   <= 4'h0;
         post_event <= 1'b0;
      end else begin
         post_event <= 1'b0;
         if (period_end) begin
            if (post_cnt >= timer_ctrl[`TPWM_POST_MSB:`TPWM_POST_LSB]) begin
               post_cnt   <= 4'h0;
               post_event <= 1'b1;
            end else begin
               post_cnt <= post_cnt + 4'h1;
            end
         end
      end
   end

   // Rollover flag: hardware set wins over software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_flags <= `TPWM_RST_IRQ;
      end else begin
         if (wr_flags) begin
            irq_flags <= wdat;
         end
         if (period_end) begin
            irq_flags[`TPWM_TMR_FLAG_BIT] <= 1'b1;
         end
      end
   end

   assign pending_duty = {duty_high_bits, mode_ctrl[`TPWM_DLOW_MSB:`TPWM_DLOW_LSB]};
   assign active_duty  = {active_duty_buffer, active_low_latch};

   // Double buffer: load only at period end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_duty_buffer <= `TPWM_RST_DUTY;
         active_low_latch   <= 2'h0;
      end else if (period_end) begin
         active_duty_buffer <= pending_duty[9:2];
         active_low_latch   <= pending_duty[1:0];
      end
   end

   // Two extra bits from quarter clock or prescaler, giving log2(4*(limit+1)) bits
   // Divide by 4 only counts 0..3, so its low bits are the sub-count there
   assign sub_bits = (pre_sel == TPWM_PRE_DIV1) ? qclk :
                     (pre_sel == TPWM_PRE_DIV4) ? pre_cnt[1:0] : pre_cnt[3:2];
   assign timebase = {period_timer_count, sub_bits};

   // Output latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_latch <= 1'b0;
      end else if (wr_mode && wdat == 8'h00) begin
         pwm_latch <= 1'b0;
      end else if (!pwm_mode) begin
         pwm_latch <= 1'b0;
      end else if (period_end) begin
         pwm_latch <= (pending_duty != 10'h000);
      end else if (!sleep && timer_ctrl[`TPWM_RUN_BIT] && active_duty == timebase) begin
         pwm_latch <= 1'b0; // duty past period never matches
      end
   end

   assign pwm_out = pwm_latch;
   assign pwm_oe  = !port_dir[`TPWM_PWM_PIN_BIT] && pwm_mode;

   // Software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ctrl      <= `TPWM_RST_MODE_CTRL;
         duty_high_bits <= `TPWM_RST_DUTY;
         irq_enable     <= `TPWM_RST_IRQ;
         period_limit   <= `TPWM_RST_PERIOD_LIMIT;
         timer_ctrl     <= `TPWM_RST_TIMER_CTRL;
         port_dir       <= `TPWM_RST_PORT_DIR;
         sys_ctrl       <= 2'h0;
      end else if (dp_write) begin
         unique case (dp_addr)
            `TPWM_OFS_MODE_CTRL:    mode_ctrl      <= {2'h0, wdat[5:0]};
            `TPWM_OFS_DUTY_HIGH:    duty_high_bits <= wdat;
            `TPWM_OFS_IRQ_ENABLE:   irq_enable     <= wdat;
            `TPWM_OFS_PERIOD_LIMIT: period_limit   <= wdat;
            `TPWM_OFS_TIMER_CTRL:   timer_ctrl     <= {1'b0, wdat[6:0]};
            `TPWM_OFS_PORT_DIR:     port_dir       <= wdat;
            `TPWM_OFS_SYS_CTRL:     sys_ctrl       <= wdat[1:0];
            default: ; // Active duty is read only
         endcase
      end
   end

   // Read data decoded combinationally in the data phase
   always_comb begin
      unique case (dp_addr)
         `TPWM_OFS_MODE_CTRL:    hrdata = {24'h000000, mode_ctrl};
         `TPWM_OFS_DUTY_HIGH:    hrdata = {24'h000000, duty_high_bits};
         `TPWM_OFS_ACTIVE_DUTY:  hrdata = {24'h000000, active_duty_buffer};
         `TPWM_OFS_IRQ_ENABLE:   hrdata = {24'h000000, irq_enable};
         `TPWM_OFS_IRQ_FLAGS:    hrdata = {24'h000000, irq_flags};
         `TPWM_OFS_PERIOD_LIMIT: hrdata = {24'h000000, period_limit};
         `TPWM_OFS_TIMER_CTRL:   hrdata = {24'h000000, timer_ctrl};
         `TPWM_OFS_TIMER_COUNT:  hrdata = {24'h000000, period_timer_count};
         `TPWM_OFS_PORT_DIR:     hrdata = {24'h000000, port_dir[7:6], port_dir[5] | pin_in & 1'b0, port_dir[4:0]};
         `TPWM_OFS_SYS_CTRL:     hrdata = {30'h00000000, sys_ctrl};
         default:                hrdata = 32'h00000000;
      endcase
   end

   a_timer_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      period_end |=> period_timer_count == 8'h00 || $past(wr_timer))
      else $error("timer not cleared after period end");

   a_duty_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      period_end |=> active_duty == $past(pending_duty))
      else $error("duty not latched at period end");

   a_duty_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !period_end |=> $stable(active_duty))
      else $error("active duty changed mid period");

   a_set_high: assert property (@(posedge hclk) disable iff (!hresetn)
      period_end && pwm_mode && pending_duty != 10'h000 && !wr_mode |=> pwm_out)
      else $error("output not set at period start");

   a_zero_duty: assert property (@(posedge hclk) disable iff (!hresetn)
      period_end && pending_duty == 10'h000 |=> !pwm_out)
      else $error("zero duty drove output high");

   a_clear_match: assert property (@(posedge hclk) disable iff (!hresetn)
      pwm_mode && !period_end && !sleep && timer_ctrl[2] && active_duty == timebase |=> !pwm_out)
      else $error("output not cleared on duty match");

   a_sleep_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
      sleep && !dp_write |=> $stable(period_timer_count) && $stable(pwm_out))
      else $error("state changed in sleep");

   a_mode_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_mode && wdat == 8'h00 |=> !pwm_out)
      else $error("mode clear did not force output low");

   a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
      period_end |=> irq_flags[1])
      else $error("rollover flag not set");

   a_ro_active: assert property (@(posedge hclk) disable iff (!hresetn)
      dp_write && dp_addr == `TPWM_OFS_ACTIVE_DUTY && !period_end |=> $stable(active_duty_buffer))
      else $error("active duty buffer was written");
endmodule

// ---- inc/tpwm_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the PWM block.
// Assumes inclusion by bare name from the core and the bench.
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

`define TPWM_OFS_MODE_CTRL     12'h000
`define TPWM_OFS_DUTY_HIGH     12'h004
`define TPWM_OFS_ACTIVE_DUTY   12'h008
`define TPWM_OFS_IRQ_ENABLE    12'h00C
`define TPWM_OFS_IRQ_FLAGS     12'h010
`define TPWM_OFS_PERIOD_LIMIT  12'h014
`define TPWM_OFS_TIMER_CTRL    12'h018
`define TPWM_OFS_TIMER_COUNT   12'h01C
`define TPWM_OFS_PORT_DIR      12'h020
`define TPWM_OFS_SYS_CTRL      12'h024

`define TPWM_MODE_LSB          0
`define TPWM_MODE_MSB          3
`define TPWM_DLOW_LSB          4
`define TPWM_DLOW_MSB          5
`define TPWM_PRE_LSB           0
`define TPWM_PRE_MSB           1
`define TPWM_RUN_BIT           2
`define TPWM_POST_LSB          3
`define TPWM_POST_MSB          6
`define TPWM_TMR_FLAG_BIT      1
`define TPWM_SLEEP_BIT         0
`define TPWM_FAILSAFE_BIT      1
`define TPWM_PWM_PIN_BIT       5

`define TPWM_RST_MODE_CTRL     8'h00
`define TPWM_RST_PERIOD_LIMIT  8'hFF
`define TPWM_RST_TIMER_CTRL    8'h00
`define TPWM_RST_TIMER_COUNT   8'h00
`define TPWM_RST_IRQ           8'h00
`define TPWM_RST_PORT_DIR      8'hFF
`define TPWM_RST_DUTY          8'h00

`define TPWM_MODE_PWM          4'hC
`define TPWM_QCLK_PER_CYCLE    4

`endif

// ---- inc/tpwm_pkg.sv ----
// Types shared by the PWM block.
// Assumes tpwm_defines.svh on the include path.
package tpwm_pkg;
   typedef enum logic [1:0] {
      TPWM_PRE_DIV1  = 2'h0,
      TPWM_PRE_DIV4  = 2'h1,
      TPWM_PRE_DIV16 = 2'h2,
      TPWM_PRE_DIV16B = 2'h3
   } tpwm_prescale_t;
   typedef logic [9:0] tpwm_duty_t;
endpackage

// ---- tb/tb.sv ----
// Self-checking bench: AHB-Lite register calls and pin measurements.
// Assumes the load model in tpwm_load.sv and zero-wait slave answers.
`timescale 1ns/100ps
`include "tpwm_defines.svh"

module tb;
   import tpwm_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        pin;
   logic        pwm_out;
   logic        pwm_oe;
   logic        clk_fail_select;
   logic        post_event;
   int          posts;
   int          r1;
   int          rises;
   int          hi_len;
   int          per_len;
   int          mismatches;
   int          n_tests;
   int          cyc;
   logic [31:0] rd;
   logic [31:0] rd2;
   logic        lvl;
   int          r0;

   tpwm_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .post_event(post_event), .clk_fail_select(clk_fail_select));
   tpwm_load load_u (.hclk(hclk), .hresetn(hresetn), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
      .pin_level(pin), .rises(rises), .hi_len(hi_len), .per_len(per_len));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches = mismatches + 1;
         tally_and_finish();
      end
   end

   // Counts postscaled period events
   always @(posedge hclk) begin
      if (post_event === 1'b1) posts <= posts + 1;
   end

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic wr(logic [11:0] a, logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, rd, exp);
   endtask

   task automatic pulses(int n);
      r0 = rises;
      while (rises < r0 + n) @(posedge hclk);
   endtask

   initial begin
      static logic [11:0] ra[7] = '{`TPWM_OFS_MODE_CTRL, `TPWM_OFS_PERIOD_LIMIT, `TPWM_OFS_TIMER_CTRL,
         `TPWM_OFS_TIMER_COUNT, `TPWM_OFS_PORT_DIR, `TPWM_OFS_IRQ_FLAGS, `TPWM_OFS_IRQ_ENABLE};
      static logic [7:0] rv[7] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
      static int dv[4] = '{1, 4, 16, 16};
      {hsel, htrans, hwrite, haddr, hwdata} = '0;
      hresetn = 1'b0;
      cyc = 0;
      mismatches = 0;
      n_tests = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++) rdchk("reset value", ra[i], {24'h0, rv[i]});
      chk("oe after reset", pwm_oe, 0);
      wr(`TPWM_OFS_ACTIVE_DUTY, 32'h0000_0055);
      rdchk("active duty write", `TPWM_OFS_ACTIVE_DUTY, 32'h0000_0000);
      rdchk("unmapped", 12'h0FC, 32'h0000_0000);
      chk("okay response", hresp, 0);
      wr(`TPWM_OFS_PORT_DIR, 32'h0000_00FF);
      wr(`TPWM_OFS_PERIOD_LIMIT, 32'h0000_0003);
      wr(`TPWM_OFS_MODE_CTRL, 32'h0000_001C);
      wr(`TPWM_OFS_DUTY_HIGH, 32'h0000_0002);
      wr(`TPWM_OFS_IRQ_FLAGS, 32'h0000_0000);
      wr(`TPWM_OFS_TIMER_CTRL, 32'h0000_0004);
      chk("oe before flag", pwm_oe, 0);
      rd = '0;
      for (int i = 0; i < 40 && rd[1] !== 1'b1; i++) bus(1'b0, `TPWM_OFS_IRQ_FLAGS, 32'h0);
      chk("rollover flag", rd[1], 1);
      wr(`TPWM_OFS_PORT_DIR, 32'h0000_00DF);
      @(negedge hclk);
      chk("oe enabled", pwm_oe, 1);
      for (int p = 0; p < 4; p++) begin
         wr(`TPWM_OFS_TIMER_CTRL, 32'h0000_002C | p);
         pulses(3);
         chk("period", per_len, 16 * dv[p]);
         // Registered clear lands one clock after the match is seen
         chk("high time", hi_len, 9 * dv[p] + 1);
      end
      rdchk("active duty", `TPWM_OFS_ACTIVE_DUTY, 32'h0000_0002);
      wr(`TPWM_OFS_TIMER_CTRL, 32'h0000_0004);
      r1 = posts;
      pulses(2);
      chk("post events", posts - r1, 2);
      wr(`TPWM_OFS_DUTY_HIGH, 32'h0000_0003);
      rdchk("held duty", `TPWM_OFS_ACTIVE_DUTY, 32'h0000_0002);
      pulses(3);
      chk("new high time", hi_len, 14);
      rdchk("new active duty", `TPWM_OFS_ACTIVE_DUTY, 32'h0000_0003);
      wr(`TPWM_OFS_DUTY_HIGH, 32'h0000_0010);
      repeat (64) @(posedge hclk);
      chk("duty beyond period", pwm_out, 1);
      wr(`TPWM_OFS_DUTY_HIGH, 32'h0000_0000);
      wr(`TPWM_OFS_MODE_CTRL, 32'h0000_000C);
      repeat (64) @(posedge hclk);
      r0 = rises;
      repeat (64) @(posedge hclk);
      chk("zero duty level", pwm_out, 0);
      chk("zero duty pulses", rises - r0, 0);
      wr(`TPWM_OFS_DUTY_HIGH, 32'h0000_0002);
      wr(`TPWM_OFS_MODE_CTRL, 32'h0000_001C);
      pulses(2);
      repeat (5) @(posedge hclk);
      wr(`TPWM_OFS_SYS_CTRL, 32'h0000_0001);
      @(negedge hclk);
      lvl = pwm_out;
      bus(1'b0, `TPWM_OFS_TIMER_COUNT, 32'h0);
      rd2 = rd;
      repeat (10) @(posedge hclk);
      rdchk("frozen count", `TPWM_OFS_TIMER_COUNT, rd2);
      chk("frozen output", pwm_out, lvl);
      wr(`TPWM_OFS_SYS_CTRL, 32'h0000_0002);
      pulses(2);
      chk("resumed period", per_len, 16);
      chk("fail-safe select", clk_fail_select, 1);
      wr(`TPWM_OFS_SYS_CTRL, 32'h0000_0000);
      wr(`TPWM_OFS_MODE_CTRL, 32'h0000_0000);
      @(posedge hclk);
      chk("mode cleared out", pwm_out, 0);
      chk("mode cleared oe", pwm_oe, 0);
      tally_and_finish();
   end
endmodule

// ---- tb/tpwm_load.sv ----
// Load model on the PWM pin: measures high time and period of each pulse.
// Assumes a pull-up on the pin, so a released pin reads high.
`timescale 1ns/100ps

module tpwm_load (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pwm_out,
   input  wire logic pwm_oe,
   output logic      pin_level,
   output int        rises,
   output int        hi_len,
   output int        per_len
);
   int   hi_c;
   int   per_c;
   logic prev;

   // Pull-up holds the released pin high
   assign pin_level = pwm_oe ? pwm_out : 1'b1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev    <= 1'b1;
         rises   <= 0;
         hi_len  <= 0;
         per_len <= 0;
         hi_c    <= 0;
         per_c   <= 0;
      end else begin
         prev  <= pin_level;
         hi_c  <= pin_level ? ((pin_level && !prev) ? 1 : hi_c + 1) : 0;
         per_c <= (pin_level && !prev) ? 1 : per_c + 1;
         if (pin_level && !prev) begin
            rises   <= rises + 1;
            per_len <= per_c;
         end
         if (!pin_level && prev) begin
            hi_len <= hi_c;
         end
      end
   end
endmodule
